// *** core/mlvirq_pkg.sv ***
// constants, source map and helpers of the vectored interrupt controller
// Function
// - three nested levels: highest above high above low
// - refuse requests not above level in service
// - highest pending level wins arbitration
// - equal levels: smallest vector address wins
// - 35 sources delivered through 10 vectors
// - ext a, b own vectors; highest or low
// - ext c, timer0 low, ext e, bus-active share
// - ext d, ext f, base timer share
// - timer0 high and ext g share
// - timer1 low, timer1 high, ext h share
// - serial a, usb reset/suspend, uart receives share
// - serial, usb endpoint/sof, uart transmit events share
// - converter, timers c and d share
// - port 0, pwm a/b, timers a/b share
// - light standby ends on interrupt or reset
// - deep standby ends on listed sources or reset only
// - ext a, b wake only when level-triggered
// - crystal standby also wakes on base timer
package mlvirq_pkg;

  localparam int NSRC = 35;
  localparam int NVEC = 10;
  localparam int SYNC_W = 3;

  // levels, ordered so that a larger code is a higher level
  localparam logic [1:0] LV_NONE = 2'h0;
  localparam logic [1:0] LV_L    = 2'h1;
  localparam logic [1:0] LV_H    = 2'h2;
  localparam logic [1:0] LV_X    = 2'h3;

  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h004B;
  localparam int          VEC_SHIFT = 3;
  localparam logic [3:0]  NUM_X_VEC = 4'h2;

  // source indices that the wake logic names
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_BASE  = 8;

  // ==========================================================
  // source to vector map
  localparam logic [3:0] SRC_VEC [NSRC] = '{
    4'h0,
    4'h1,
    4'h2, 4'h2, 4'h2, 4'h2,
    4'h3, 4'h3, 4'h3,
    4'h4, 4'h4,
    4'h5, 4'h5, 4'h5,
    4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
    4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
    4'h8, 4'h8, 4'h8,
    4'h9, 4'h9, 4'h9, 4'h9, 4'h9
  };

  // ext c, ext e, bus active, ext f, port 0
  localparam logic [NSRC-1:0] DEEP_WAKE_MASK = 35'h0_4000_00B4;
  localparam logic [NSRC-1:0] XTAL_WAKE_MASK = 35'h0_4000_01B4;

  typedef enum logic [1:0] {
    MLV_IDLE  = 2'b01,
    MLV_OFFER = 2'b10
  } mlv_state_t;

  // level a vector runs at: its select picks the upper or low level
  function automatic logic [1:0] mlv_lvl_of(logic [3:0] v, logic hi);
    if (!hi)
      return LV_L;
    return (v < NUM_X_VEC) ? LV_X : LV_H;
  endfunction : mlv_lvl_of

  // highest level among those in service
  function automatic logic [1:0] mlv_top_lvl(logic [2:0] m);
    if (m[2])
      return LV_X;
    if (m[1])
      return LV_H;
    return m[0] ? LV_L : LV_NONE;
  endfunction : mlv_top_lvl

endpackage : mlvirq_pkg

// *** core/mlvirq_flags.sv ***
// per-source request flags, enables and per-vector merge
module mlvirq_flags
  import mlvirq_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // source side
  input  wire logic [NSRC-1:0] src_set,
  input  wire logic [NSRC-1:0] src_clr,
  input  wire logic [NSRC-1:0] src_en,
  // results
  output logic      [NSRC-1:0] flag,
  output logic      [NVEC-1:0] vec_pend
);

  typedef struct packed {
    logic [NSRC-1:0] flag;
  } mlv_flag_st_t;

  mlv_flag_st_t st_r;
  mlv_flag_st_t st_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    st_nxt      = st_r;
    st_nxt.flag = (st_r.flag & ~src_clr) | src_set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign flag = st_r.flag;

  always_comb begin
    vec_pend = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (st_r.flag[i] && src_en[i])
        vec_pend[SRC_VEC[i]] = 1'b1;
    end
  end

  property p_set_pend;
    @(posedge clk) disable iff (sys_rst)
    src_set[3] && src_en[3] ##1 src_en[3] |-> vec_pend[2];
  endproperty
  a_set_pend: assert property (p_set_pend)
    else $error("set source did not raise its vector");

endmodule : mlvirq_flags

// *** core/mlvirq_arb.sv ***
// level then address arbitration over pending vectors
module mlvirq_arb
  import mlvirq_pkg::*;
(
  // pending vectors and their level selects
  input  wire logic [NVEC-1:0] vec_pend,
  input  wire logic [NVEC-1:0] vec_hi,
  input  wire logic [1:0]      cur_lvl,
  // winner
  output logic                 gnt_vld,
  output logic      [3:0]      gnt_idx,
  output logic      [1:0]      gnt_lvl
);

  logic [1:0] lv;

  // scan downward so an equal level at a smaller address replaces
  always_comb begin
    gnt_idx = '0;
    gnt_lvl = LV_NONE;
    lv      = LV_NONE;
    for (int v = NVEC - 1; v >= 0; v--) begin
      lv = mlv_lvl_of(4'(v), vec_hi[v]);
      if (vec_pend[v] && lv >= gnt_lvl) begin
        gnt_idx = 4'(v);
        gnt_lvl = lv;
      end
    end
    gnt_vld = (gnt_lvl != LV_NONE) && (gnt_lvl > cur_lvl);
  end

endmodule : mlvirq_arb

// *** core/mlvirq_top.sv ***
// vectored interrupt controller with nesting and standby wake
module mlvirq_top
  import mlvirq_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // external pins
  input  wire logic            ext_irq_a,
  input  wire logic            ext_irq_b,
  input  wire logic            rst_pin_n,
  input  wire logic [1:0]      ext_trig_level,
  input  wire logic [1:0]      ext_active_high,
  // peripheral sources
  input  wire logic [NSRC-1:0] src_evt,
  input  wire logic [NSRC-1:0] src_en,
  input  wire logic [NSRC-1:0] src_clr,
  input  wire logic [NVEC-1:0] vec_hi,
  // cpu side
  output logic                 irq_req,
  output logic      [15:0]     irq_vec,
  output logic      [1:0]      irq_lvl,
  input  wire logic            irq_ack,
  input  wire logic            irq_ret,
  output logic      [1:0]      cur_lvl,
  // standby
  input  wire logic            stby_light,
  input  wire logic            stby_deep,
  input  wire logic            stby_xtal,
  input  wire logic            wdt_rst,
  input  wire logic            lvr_rst,
  output logic                 wake
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] flt;
    logic [1:0]        act_prev;
    mlv_state_t        state;
    logic [15:0]       vaddr;
    logic [1:0]        lvl;
    logic [2:0]        isr;
    logic              wake;
  } mlv_top_st_t;

  // pins preset active-looking: act_prev starts set so no false edge
  localparam mlv_top_st_t ST_RST = '{
    s1: 3'h7, s2: 3'h7, s3: 3'h7, flt: 3'h7, act_prev: 2'h3,
    state: MLV_IDLE, vaddr: VEC_BASE, lvl: LV_NONE, isr: 3'h0,
    wake: 1'b0
  };

  mlv_top_st_t st_r;
  mlv_top_st_t st_nxt;

  logic [1:0]      ext_act;
  logic [1:0]      ext_set;
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] flag;
  logic [NVEC-1:0] vec_pend;
  logic            gnt_vld;
  logic [3:0]      gnt_idx;
  logic [1:0]      gnt_lvl;
  logic            rst_cause;
  logic            deep_cause;
  logic            xtal_cause;
  logic [NSRC-1:0] live;

  // ==========================================================
  // pin conditioning and request sources
  assign ext_act = ~(st_r.flt[1:0] ^ ext_active_high);
  assign ext_set = ext_act & (ext_trig_level | ~st_r.act_prev);
  assign src_set = {src_evt[NSRC-1:2], ext_set};
  assign cur_lvl = mlv_top_lvl(st_r.isr);
  assign live    = flag & src_en;

  mlvirq_flags u_flags (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .src_set  (src_set),
    .src_clr  (src_clr),
    .src_en   (src_en),
    .flag     (flag),
    .vec_pend (vec_pend)
  );

  mlvirq_arb u_arb (
    .vec_pend (vec_pend),
    .vec_hi   (vec_hi),
    .cur_lvl  (cur_lvl),
    .gnt_vld  (gnt_vld),
    .gnt_idx  (gnt_idx),
    .gnt_lvl  (gnt_lvl)
  );

  // ==========================================================
  // wake causes
  assign rst_cause  = ~st_r.flt[2] | wdt_rst | lvr_rst;
  // ext a and b count only in level detection
  assign deep_cause = |(live & DEEP_WAKE_MASK)
                    | |(live[1:0] & ext_trig_level);
  assign xtal_cause = deep_cause | live[SRC_BASE];

  // ==========================================================
  // next state
  always_comb begin
    st_nxt          = st_r;
    st_nxt.s1       = {rst_pin_n, ext_irq_b, ext_irq_a};
    st_nxt.s2       = st_r.s1;
    st_nxt.s3       = st_r.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.flt[i] = st_r.s3[i];
    end
    st_nxt.act_prev = ext_act;
    if (irq_ret) begin
      if (st_r.isr[2])
        st_nxt.isr[2] = 1'b0;
      else if (st_r.isr[1])
        st_nxt.isr[1] = 1'b0;
      else
        st_nxt.isr[0] = 1'b0;
    end
    unique case (st_r.state)
      MLV_IDLE: begin
        if (gnt_vld) begin
          st_nxt.state = MLV_OFFER;
          st_nxt.vaddr = VEC_BASE + {gnt_idx, 3'h0};
          st_nxt.lvl   = gnt_lvl;
        end
      end
      MLV_OFFER: begin
        if (irq_ack) begin
          st_nxt.state                = MLV_IDLE;
          st_nxt.isr[st_r.lvl - 2'h1] = 1'b1;
        end else if (!gnt_vld) begin
          st_nxt.state = MLV_IDLE;
        end else begin
          st_nxt.vaddr = VEC_BASE + {gnt_idx, 3'h0};
          st_nxt.lvl   = gnt_lvl;
        end
      end
    endcase
    st_nxt.wake = (stby_light & (gnt_vld | rst_cause))
                | (stby_deep & (deep_cause | rst_cause))
                | (stby_xtal & (xtal_cause | rst_cause));
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  assign irq_req = (st_r.state == MLV_OFFER);
  assign irq_vec = st_r.vaddr;
  assign irq_lvl = st_r.lvl;
  assign wake    = st_r.wake;

  // ==========================================================
  // checks
  logic beat_lvl;
  logic beat_tie;
  always_comb begin
    beat_lvl = 1'b0;
    beat_tie = 1'b0;
    for (int v = 0; v < NVEC; v++) begin
      if (vec_pend[v] && mlv_lvl_of(4'(v), vec_hi[v]) > gnt_lvl)
        beat_lvl = 1'b1;
      if (vec_pend[v] && mlv_lvl_of(4'(v), vec_hi[v]) == gnt_lvl
          && 4'(v) < gnt_idx)
        beat_tie = 1'b1;
    end
  end

  property p_above_cur;
    @(posedge clk) disable iff (sys_rst)
    irq_req && !irq_ret |-> irq_lvl > cur_lvl;
  endproperty
  a_above_cur: assert property (p_above_cur)
    else $error("offered level not above level in service");

  property p_push;
    @(posedge clk) disable iff (sys_rst)
    irq_req && irq_ack && !irq_ret |=> cur_lvl == $past(irq_lvl);
  endproperty
  a_push: assert property (p_push)
    else $error("taken level not placed in service");

  property p_top_lvl;
    @(posedge clk) disable iff (sys_rst)
    gnt_vld |-> !beat_lvl && vec_pend[gnt_idx];
  endproperty
  a_top_lvl: assert property (p_top_lvl)
    else $error("a higher level vector was passed over");

  property p_tie;
    @(posedge clk) disable iff (sys_rst)
    gnt_vld |-> !beat_tie;
  endproperty
  a_tie: assert property (p_tie)
    else $error("a smaller address of equal level was passed over");

  property p_vec_fmt;
    @(posedge clk) disable iff (sys_rst)
    irq_req |-> irq_vec[2:0] == 3'h3 && irq_vec <= VEC_LAST;
  endproperty
  a_vec_fmt: assert property (p_vec_fmt)
    else $error("vector address outside the ten vectors");

  property p_x_or_l;
    @(posedge clk) disable iff (sys_rst)
    irq_req |-> (irq_vec < 16'h0013) ? irq_lvl != LV_H
                                     : irq_lvl != LV_X;
  endproperty
  a_x_or_l: assert property (p_x_or_l)
    else $error("vector offered at a level it cannot take");

  property p_light;
    @(posedge clk) disable iff (sys_rst)
    stby_light && gnt_vld |=> wake;
  endproperty
  a_light: assert property (p_light)
    else $error("light standby not ended by interrupt");

  property p_deep_only;
    @(posedge clk) disable iff (sys_rst)
    stby_deep && !stby_light && !stby_xtal && !deep_cause
      && !rst_cause |=> !wake;
  endproperty
  a_deep_only: assert property (p_deep_only)
    else $error("deep standby woken by a source it ignores");

  property p_level_wake;
    @(posedge clk) disable iff (sys_rst)
    stby_deep && ext_trig_level[0] && live[SRC_EXT_A] |=> wake;
  endproperty
  a_level_wake: assert property (p_level_wake)
    else $error("level-triggered pin did not wake deep standby");

  property p_xtal;
    @(posedge clk) disable iff (sys_rst)
    stby_xtal && live[SRC_BASE] |=> wake;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("base timer did not end crystal standby");

  property p_rst_quiet;
    @(posedge clk)
    sys_rst |=> !irq_req && !wake && cur_lvl == LV_NONE;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");

  property p_drop;
    @(posedge clk) disable iff (sys_rst)
    irq_req && !irq_ack && !gnt_vld |=> !irq_req;
  endproperty
  a_drop: assert property (p_drop)
    else $error("offer kept with nothing qualifying");

  property p_follow;
    @(posedge clk) disable iff (sys_rst)
    irq_req && !irq_ack && gnt_vld |=> irq_req
      && irq_lvl == $past(gnt_lvl);
  endproperty
  a_follow: assert property (p_follow)
    else $error("standing offer not re-arbitrated");

  property p_ack_end;
    @(posedge clk) disable iff (sys_rst)
    irq_req && irq_ack |=> !irq_req;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("offer still standing after it was taken");

  property p_pop;
    @(posedge clk) disable iff (sys_rst)
    irq_ret && !irq_ack && cur_lvl != LV_NONE |=> cur_lvl < $past(cur_lvl);
  endproperty
  a_pop: assert property (p_pop)
    else $error("return did not lower the level in service");

  property p_start;
    @(posedge clk) disable iff (sys_rst)
    !irq_req && gnt_vld |=> irq_req && irq_vec[6:3] == $past(gnt_idx);
  endproperty
  a_start: assert property (p_start)
    else $error("granted vector not offered");

  property p_xtal_deep;
    @(posedge clk) disable iff (sys_rst)
    stby_xtal && (deep_cause || rst_cause) |=> wake;
  endproperty
  a_xtal_deep: assert property (p_xtal_deep)
    else $error("crystal standby ignored a deep wake source");

  property p_edge_quiet;
    @(posedge clk) disable iff (sys_rst)
    stby_deep && !stby_light && !stby_xtal && !ext_trig_level[0]
      && !rst_cause && live[NSRC-1:1] == '0 |=> !wake;
  endproperty
  a_edge_quiet: assert property (p_edge_quiet)
    else $error("edge-triggered pin woke deep standby");

  property p_light_rst;
    @(posedge clk) disable iff (sys_rst)
    stby_light && rst_cause |=> wake;
  endproperty
  a_light_rst: assert property (p_light_rst)
    else $error("light standby not ended by reset cause");

  property p_deep_wake;
    @(posedge clk) disable iff (sys_rst)
    stby_deep && deep_cause |=> wake;
  endproperty
  a_deep_wake: assert property (p_deep_wake)
    else $error("deep standby not ended by a listed source");

endmodule : mlvirq_top

// *** sim/mlvirq_cpu_model.sv ***
// cpu side model: takes a standing offer after a chosen delay
module mlvirq_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // bench control
  input  wire logic       take_en,
  input  wire logic [3:0] take_dly,
  // controller side
  input  wire logic       irq_req,
  output logic            irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // ack stands one cycle; a dropped offer restarts the wait
  initial begin
    irq_ack = 1'b0;
    wait_r = 4'h0;
    forever begin
      @(posedge clk);
      #1;
      if (sys_rst || !take_en || irq_req !== 1'b1) begin
        irq_ack = 1'b0;
        wait_r = 4'h0;
      end else if (wait_r >= take_dly) begin
        irq_ack = 1'b1;
        wait_r = 4'h0;
      end else begin
        irq_ack = 1'b0;
        wait_r = wait_r + 4'h1;
      end
    end
  end
endmodule : mlvirq_cpu_model

// *** sim/mlvirq_tb_top.sv ***
// bench for the vectored interrupt controller
module mlvirq_tb_top import mlvirq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk, sys_rst, ext_irq_a, ext_irq_b, rst_pin_n;
  logic [1:0]      ext_trig_level, ext_active_high, irq_lvl, cur_lvl;
  logic [NSRC-1:0] src_evt, src_en, src_clr;
  logic [NVEC-1:0] vec_hi;
  logic [15:0]     irq_vec;
  logic            irq_req, irq_ack, irq_ret, wake, wdt_rst, lvr_rst;
  logic            stby_light, stby_deep, stby_xtal, take_en;
  logic [3:0]      take_dly;
  int              n_errors = 0;
  int              num_checks = 0;

  mlvirq_top dut_u (.clk, .sys_rst, .ext_irq_a, .ext_irq_b, .rst_pin_n,
    .ext_trig_level, .ext_active_high, .src_evt, .src_en, .src_clr,
    .vec_hi, .irq_req, .irq_vec, .irq_lvl, .irq_ack, .irq_ret, .cur_lvl,
    .stby_light, .stby_deep, .stby_xtal, .wdt_rst, .lvr_rst, .wake);
  mlvirq_cpu_model cpu_u (.clk, .sys_rst, .take_en, .take_dly, .irq_req,
    .irq_ack);

  // ==========================================================
  // helpers
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pmask(logic [NSRC-1:0] m);
    src_evt = m;
    tick();
    src_evt = '0;
  endtask : pmask

  task automatic cmask(logic [NSRC-1:0] m);
    src_clr = m;
    tick();
    src_clr = '0;
  endtask : cmask

  task automatic wreq();
    for (int k = 0; k < 10 && irq_req !== 1'b1; k++)
      tick();
    chk(irq_req, 16'h0001);
  endtask : wreq

  task automatic take(logic [1:0] lvl, logic [3:0] dly);
    take_dly = dly;
    take_en = 1'b1;
    for (int k = 0; k < 12 && cur_lvl !== lvl; k++)
      tick();
    take_en = 1'b0;
    chk(cur_lvl, lvl);
  endtask : take

  task automatic ret(logic [1:0] lvl);
    irq_ret = 1'b1;
    tick();
    irq_ret = 1'b0;
    tick();
    chk(cur_lvl, lvl);
  endtask : ret

  // vector index of each source, by groups of the vector table
  function automatic logic [3:0] vmap(int i);
    return i < 2 ? 4'(i) : i < 6 ? 4'h2 : i < 9 ? 4'h3 : i < 11 ? 4'h4 :
      i < 14 ? 4'h5 : i < 19 ? 4'h6 : i < 27 ? 4'h7 : i < 30 ? 4'h8 : 4'h9;
  endfunction : vmap

  // ==========================================================
  // scenarios
  task automatic t_map();
    for (int i = 2; i < NSRC; i++) begin
      pmask(35'h0_0000_0001 << i);
      tick();
      chk(irq_req, 16'h0001);
      chk(irq_vec, 16'h0003 + {9'h000, vmap(i), 3'h0});
      chk(irq_lvl, 16'h0001);
      cmask(35'h0_0000_0001 << i);
      tick();
      chk(irq_req, 16'h0000);
    end
  endtask : t_map

  task automatic t_arb(logic [NSRC-1:0] m, logic [NVEC-1:0] hi,
                       logic [15:0] ev, logic [1:0] el);
    vec_hi = hi;
    pmask(m);
    tick();
    chk(irq_vec, ev);
    chk(irq_lvl, el);
    cmask(m);
    vec_hi = '0;
    tick();
  endtask : t_arb

  task automatic t_en();
    src_en[27] = 1'b0;
    pmask(35'h0_0800_0000);
    tick(3);
    chk(irq_req, 16'h0000);
    src_en[27] = 1'b1;
    tick(2);
    chk(irq_vec, 16'h0043);
    cmask(35'h0_0800_0000);
    tick();
  endtask : t_en

  task automatic t_nest();
    pmask(35'h0_0000_0400);
    take(2'h1, 4'h0);
    cmask(35'h0_0000_0400);
    pmask(35'h0_0000_0200);
    tick(3);
    chk(irq_req, 16'h0000);
    vec_hi[9] = 1'b1;
    pmask(35'h0_8000_0000);
    wreq();
    chk(irq_vec, 16'h004B);
    take(2'h2, 4'h3);
    cmask(35'h0_8000_0000);
    vec_hi[0] = 1'b1;
    ext_irq_a = 1'b1;
    wreq();
    chk(irq_vec, 16'h0003);
    chk(irq_lvl, 16'h0003);
    take(2'h3, 4'h1);
    ext_irq_a = 1'b0;
    tick(6);
    cmask(35'h0_0000_0001);
    ret(2'h2);
    ret(2'h1);
    chk(irq_req, 16'h0000);
    ret(2'h0);
    wreq();
    chk(irq_vec, 16'h0023);
    cmask(35'h0_0000_0200);
    vec_hi = '0;
    tick(2);
  endtask : t_nest

  task automatic t_stby();
    stby_deep = 1'b1;
    pmask(35'h0_0000_0100);
    tick();
    chk(wake, 16'h0000);
    stby_deep = 1'b0;
    stby_xtal = 1'b1;
    tick(2);
    chk(wake, 16'h0001);
    stby_xtal = 1'b0;
    stby_light = 1'b1;
    tick(2);
    chk(wake, 16'h0001);
    cmask(35'h0_0000_0100);
    tick(2);
    chk(wake, 16'h0000);
    stby_light = 1'b0;
    stby_deep = 1'b1;
    pmask(35'h0_0000_0010);
    tick();
    chk(wake, 16'h0001);
    cmask(35'h0_0000_0010);
    wdt_rst = 1'b1;
    tick(2);
    chk(wake, 16'h0001);
    wdt_rst = 1'b0;
    rst_pin_n = 1'b0;
    tick(6);
    chk(wake, 16'h0001);
    rst_pin_n = 1'b1;
    ext_irq_a = 1'b1;
    tick(8);
    chk(wake, 16'h0000);
    ext_trig_level = 2'h1;
    tick(3);
    chk(wake, 16'h0001);
    ext_irq_a = 1'b0;
    tick(6);
    ext_trig_level = 2'h0;
    cmask(35'h0_0000_0001);
    stby_deep = 1'b0;
    tick(2);
    chk(wake, 16'h0000);
  endtask : t_stby

  // pin b active low in level mode, highest level, deep wake
  task automatic t_pin_b();
    ext_irq_b = 1'b1;
    tick(6);
    ext_active_high = 2'h1;
    cmask(35'h0_0000_0002);
    tick();
    chk(irq_req, 16'h0000);
    vec_hi[1] = 1'b1;
    ext_trig_level = 2'h2;
    stby_deep = 1'b1;
    ext_irq_b = 1'b0;
    tick(6);
    chk(irq_vec, 16'h000B);
    chk(irq_lvl, 16'h0003);
    chk(wake, 16'h0001);
    ext_irq_b = 1'b1;
    tick(6);
    cmask(35'h0_0000_0002);
    tick();
    chk(wake, 16'h0000);
    chk(irq_req, 16'h0000);
    stby_deep = 1'b0;
    stby_light = 1'b1;
    lvr_rst = 1'b1;
    tick(2);
    chk(wake, 16'h0001);
    {stby_light, lvr_rst} = '0;
  endtask : t_pin_b

  // ==========================================================
  // clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    {ext_irq_a, ext_irq_b, irq_ret, wdt_rst, lvr_rst} = '0;
    {stby_light, stby_deep, stby_xtal, take_en} = '0;
    rst_pin_n = 1'b1;
    ext_trig_level = 2'h0;
    ext_active_high = 2'h3;
    src_evt = '0;
    src_clr = '0;
    src_en = '1;
    vec_hi = '0;
    take_dly = 4'h0;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    tick(6);
    chk(irq_req, 16'h0000);
    chk(irq_vec, 16'h0003);
    t_map();
    t_arb(35'h0_4000_0004, 10'h200, 16'h004B, 2'h2);
    t_arb(35'h0_0000_0840, 10'h000, 16'h001B, 2'h1);
    t_arb(35'h2_0000_2200, 10'h220, 16'h002B, 2'h2);
    t_en();
    t_nest();
    t_stby();
    t_pin_b();
    conclude();
  end

  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule : mlvirq_tb_top
